// >>> design/scd_regs.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// register file for sample-clock delay, detection and stabilizer controls
module scd_regs
  import scd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  // monitored input clock (asynchronous)
  input wire logic clkMonitor,
  // frame sync capture error events from the capture logic
  input wire logic syncSetupErr,
  input wire logic syncHoldErr,
  // applied delay controls
  output logic [DATA_W-1:0] localFineApplied,
  output logic [DATA_W-1:0] digitalFineApplied,
  output logic [DATA_W-1:0] digitalSuperApplied,
  output logic fineLimited,
  // stabilizer controls
  output logic stabilizerOneActive,
  output logic stabilizerOnePowered,
  output logic stabilizerTwoActive,
  output logic stabilizerTwoPowered,
  // frame sync flags
  output logic syncSetupFlag,
  output logic syncHoldFlag,
  output logic syncFlagsHeld,
  // status
  output logic clockPresent,
  output logic irq
);
  // stored registers
  logic [MODE_W-1:0] delayMode; // delay mode select
  logic [DATA_W-1:0] localClockFineDelay;
  logic [DATA_W-1:0] digitalClockSuperfineDelay;
  logic [DATA_W-1:0] digitalClockFineDelay;
  logic [DATA_W-1:0] clockDetectControl;
  logic [DATA_W-1:0] dutyStabilizerOneControl;
  logic [DATA_W-1:0] dutyStabilizerTwoControl;
  logic [DATA_W-1:0] frameSyncControlOne;
  logic [IRQ_W-1:0] irqStatus; // sticky events
  logic [IRQ_W-1:0] irqMask; // one enables
  // detector and helpers
  logic detPresent; // detector verdict
  logic detPrev; // previous verdict for edge events
  logic fineOn; // fine delay in use
  logic superOn; // super-fine in use
  logic limitOn; // drives fineLimited only; applied fine not clamped to 0..16
  logic [IRQ_W-1:0] irqEvent;
  logic [DATA_W-1:0] next_rdata;
  logic wrHit;

  // presence detector on the monitor input
  scd_clock_detect u_detect (
    .mclk(mclk),
    .rst(rst),
    .clkIn(clkMonitor),
    .thrSel(clockDetectControl[THR_HI:THR_LO]),
    .present(detPresent)
  );

  assign wrHit = regWr;

  // mode decode
  always_comb begin
    fineOn = 1'b0;
    superOn = 1'b0;
    limitOn = 1'b0;
    case (delayMode)
      MODE_NONE: begin
        fineOn = 1'b0; // no delay
      end
      MODE_FINE_A, MODE_FINE_B: begin
        fineOn = 1'b1;
        limitOn = 1'b1;
      end
      MODE_FINE_ALL: begin
        fineOn = 1'b1; // all steps valid
      end
      MODE_FINE_SUPER: begin
        fineOn = 1'b1;
        superOn = 1'b1;
      end
      default: begin
        fineOn = 1'b0; // reserved codes apply nothing
      end
    endcase
    // super-fine is also honoured in mode 010
    if (delayMode == MODE_FINE_A) begin
      superOn = 1'b1;
    end
  end

  // delay mode and fine/super-fine delay registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      delayMode <= MODE_NONE;
      localClockFineDelay <= RST_FINE;
      digitalClockSuperfineDelay <= RST_SUPER;
      digitalClockFineDelay <= RST_FINE;
    end else if (wrHit) begin
      case (regAddr)
        OFS_DELAY_MODE: delayMode <= regWdata[MODE_W-1:0];
        OFS_LOCAL_FINE: localClockFineDelay <= regWdata;
        OFS_DIG_SUPER: digitalClockSuperfineDelay <= regWdata;
        OFS_DIG_FINE: digitalClockFineDelay <= regWdata;
        default: begin
          // other offsets handled elsewhere
        end
      endcase
    end
  end

  // detection and stabilizer controls
  always_ff @(posedge mclk) begin
    if (rst) begin
      clockDetectControl <= RST_DETECT; // threshold code 01
      dutyStabilizerOneControl <= RST_STAB;
      dutyStabilizerTwoControl <= RST_STAB;
      frameSyncControlOne <= RST_ZERO;
    end else if (wrHit) begin
      case (regAddr)
        OFS_DETECT_CTRL: clockDetectControl <= regWdata;
        OFS_STAB_ONE: dutyStabilizerOneControl <= regWdata;
        OFS_STAB_TWO: dutyStabilizerTwoControl <= regWdata;
        // bits 7, 5 and 0 are read-only zero
        OFS_SYNC_CTRL: frameSyncControlOne <= regWdata & SYNC_WR_MASK;
        default: begin
          // status offset ignores writes
        end
      endcase
    end
  end

  // applied delays; zero when the mode leaves the path unused
  always_ff @(posedge mclk) begin
    if (rst) begin
      localFineApplied <= RST_ZERO;
      digitalFineApplied <= RST_ZERO;
      digitalSuperApplied <= RST_ZERO;
      fineLimited <= 1'b0;
    end else begin
      // fine values above 192 and super-fine values above 128 are saturated rather than trusted
      localFineApplied <= !fineOn ? RST_ZERO :
        (localClockFineDelay > FINE_MAX ? FINE_MAX
         : localClockFineDelay);
      digitalFineApplied <= !fineOn ? RST_ZERO :
        (digitalClockFineDelay > FINE_MAX ? FINE_MAX
         : digitalClockFineDelay);
      digitalSuperApplied <= !superOn ? RST_ZERO :
        (digitalClockSuperfineDelay > SUPER_MAX ? SUPER_MAX
         : digitalClockSuperfineDelay);
      fineLimited <= limitOn;
    end
  end

  // stabilizer outputs follow their control bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      stabilizerOneActive <= 1'b1;
      stabilizerOnePowered <= 1'b1;
      stabilizerTwoActive <= 1'b1;
      stabilizerTwoPowered <= 1'b1;
    end else begin
      stabilizerOneActive <= dutyStabilizerOneControl[STAB_ACTIVE_BIT];
      stabilizerOnePowered <= dutyStabilizerOneControl[STAB_POWER_BIT];
      stabilizerTwoActive <= dutyStabilizerTwoControl[STAB_ACTIVE_BIT];
      stabilizerTwoPowered <= dutyStabilizerTwoControl[STAB_POWER_BIT];
    end
  end

  // clock status, resets to not detected
  always_ff @(posedge mclk) begin
    if (rst) begin
      clockPresent <= 1'b0;
      detPrev <= 1'b0;
    end else begin
      clockPresent <= detPresent;
      detPrev <= detPresent;
    end
  end

  // frame sync setup/hold flags; held clear while reset bit is one
  always_ff @(posedge mclk) begin
    if (rst) begin
      syncSetupFlag <= 1'b0;
      syncHoldFlag <= 1'b0;
      syncFlagsHeld <= 1'b0;
    end else begin
      syncFlagsHeld <= frameSyncControlOne[FLAG_RST_BIT];
      if (frameSyncControlOne[FLAG_RST_BIT]) begin
        syncSetupFlag <= 1'b0;
        syncHoldFlag <= 1'b0;
      end else begin
        if (syncSetupErr) syncSetupFlag <= 1'b1;
        if (syncHoldErr) syncHoldFlag <= 1'b1;
      end
    end
  end

  // interrupt events
  always_comb begin
    irqEvent = '0;
    irqEvent[IRQ_CLK_UP] = detPresent && !detPrev;
    irqEvent[IRQ_CLK_DOWN] = !detPresent && detPrev;
    irqEvent[IRQ_SYNC_ERR] = (syncSetupErr || syncHoldErr) &&
      !frameSyncControlOne[FLAG_RST_BIT];
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqStatus <= '0;
      irqMask <= '0;
    end else begin
      if (wrHit && regAddr == OFS_IRQ_MASK) begin
        irqMask <= regWdata[IRQ_W-1:0];
      end
      if (wrHit && regAddr == OFS_IRQ_STATUS) begin
        irqStatus <= (irqStatus & ~regWdata[IRQ_W-1:0]) | irqEvent;
      end else begin
        irqStatus <= irqStatus | irqEvent;
      end
    end
  end

  // interrupt line level
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = RST_ZERO;
    case (regAddr)
      OFS_DELAY_MODE: next_rdata = {5'h00, delayMode};
      OFS_LOCAL_FINE: next_rdata = localClockFineDelay;
      OFS_DIG_SUPER: next_rdata = digitalClockSuperfineDelay;
      OFS_DIG_FINE: next_rdata = digitalClockFineDelay;
      OFS_DETECT_CTRL: next_rdata = clockDetectControl;
      OFS_CLK_STATUS: next_rdata[STAT_BIT] = clockPresent;
      OFS_STAB_ONE: next_rdata = dutyStabilizerOneControl;
      OFS_STAB_TWO: next_rdata = dutyStabilizerTwoControl;
      OFS_SYNC_CTRL: next_rdata = frameSyncControlOne;
      OFS_IRQ_STATUS: next_rdata = {5'h00, irqStatus};
      OFS_IRQ_MASK: next_rdata = {5'h00, irqMask};
      default: next_rdata = RST_ZERO;
    endcase
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata <= RST_ZERO;
    end else if (regRd) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= RST_ZERO;
    end
  end
endmodule : scd_regs
`default_nettype wire

// >>> design/scd_pkg.sv
// Function
// - local fine delay, 1.725 ps steps, modes 2/3/4/6
// - fine delays 0..192, reset to 192
// - digital fine delay, same modes, reset 0xC0
// - super-fine 0.25 ps, modes 010/110, reset zero
// - threshold field bits 4:3, codes 01/11, reset 01
// - clock status bit 0 read-only, resets zero
// - flag-reset bit 6 holds setup/hold flags clear
// - delay mode decode none/fine192+limit flag/fine192/fine+super
`default_nettype none
package scd_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [11:0] OFS_DELAY_MODE = 12'h110;
  localparam logic [11:0] OFS_LOCAL_FINE = 12'h112;
  localparam logic [11:0] OFS_DIG_SUPER = 12'h113;
  localparam logic [11:0] OFS_DIG_FINE = 12'h114;
  localparam logic [11:0] OFS_DETECT_CTRL = 12'h11A;
  localparam logic [11:0] OFS_CLK_STATUS = 12'h11B;
  localparam logic [11:0] OFS_STAB_ONE = 12'h11C;
  localparam logic [11:0] OFS_STAB_TWO = 12'h11E;
  localparam logic [11:0] OFS_SYNC_CTRL = 12'h120;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h130;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h131;
  // reset values
  localparam logic [7:0] RST_FINE = 8'hC0;
  localparam logic [7:0] RST_SUPER = 8'h00;
  localparam logic [7:0] RST_DETECT = 8'h0E;
  localparam logic [7:0] RST_STAB = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // limits
  localparam logic [7:0] FINE_MAX = 8'hC0;
  localparam logic [7:0] FINE_LIMITED_MAX = 8'h10;
  localparam logic [7:0] SUPER_MAX = 8'h80;
  // field positions
  localparam int THR_LO = 3;
  localparam int THR_HI = 4;
  localparam int STAT_BIT = 0;
  localparam int FLAG_RST_BIT = 6;
  localparam int STAB_ACTIVE_BIT = 1; // stabilizer enable bit
  localparam int STAB_POWER_BIT = 0; // stabilizer power-up bit
  // writable frame sync bits; 7, 5 and 0 always read zero
  localparam logic [7:0] SYNC_WR_MASK = 8'h5E;
  localparam int MODE_W = 3;
  localparam logic [1:0] THR_ONE = 2'h1;
  localparam logic [1:0] THR_TWO = 2'h3;
  // delay modes
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_FINE_A = 3'h2;
  localparam logic [2:0] MODE_FINE_B = 3'h3;
  localparam logic [2:0] MODE_FINE_ALL = 3'h4;
  localparam logic [2:0] MODE_FINE_SUPER = 3'h6;
  // detector window: clock edges counted per window
  localparam int WIN_W = 8;
  localparam logic [7:0] WIN_LEN = 8'hFF;
  localparam logic [7:0] THR_ONE_EDGES = 8'h40;
  localparam logic [7:0] THR_TWO_EDGES = 8'h08;
  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_CLK_UP = 0;
  localparam int IRQ_CLK_DOWN = 1;
  localparam int IRQ_SYNC_ERR = 2;
endpackage : scd_pkg
`default_nettype wire

// >>> design/scd_clock_detect.sv
`timescale 1ns/1ps
`default_nettype none
// counts sampled clock edges per window; present if count meets threshold
module scd_clock_detect
  import scd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sampled monitor clock and threshold code
  input wire logic clkIn,
  input wire logic [1:0] thrSel,
  // result
  output logic present
);
  logic [2:0] sync; // three-stage synchroniser
  logic prevLvl; // last settled level
  logic [WIN_W-1:0] winCnt; // window position
  logic [WIN_W-1:0] edgeCnt; // edges this window
  logic [WIN_W-1:0] need; // edges needed
  logic edgeSeen;

  // second and third stages agree before a change counts
  assign edgeSeen = (sync[2] == sync[1]) && (sync[2] != prevLvl);
  // code 11 selects the low-rate threshold, else threshold one
  assign need = (thrSel == THR_TWO) ? THR_TWO_EDGES : THR_ONE_EDGES;

  // synchroniser chain
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], clkIn};
    end
  end

  // settled level tracker
  always_ff @(posedge mclk) begin
    if (rst) begin
      prevLvl <= 1'b0;
    end else if (sync[2] == sync[1]) begin
      prevLvl <= sync[2];
    end
  end

  // window and edge counters, verdict at window end
  always_ff @(posedge mclk) begin
    if (rst) begin
      winCnt <= '0;
      edgeCnt <= '0;
      present <= 1'b0;
    end else if (winCnt == WIN_LEN) begin
      winCnt <= '0;
      edgeCnt <= '0;
      present <= (edgeCnt >= need);
    end else begin
      winCnt <= winCnt + 1'b1;
      if (edgeSeen && edgeCnt != WIN_LEN) begin
        edgeCnt <= edgeCnt + 1'b1;
      end
    end
  end
endmodule : scd_clock_detect
`default_nettype wire

// >>> tb/scd_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on read data, applied delays and sync flags
module scd_regs_checker
  import scd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdata,
  // applied delays
  input wire logic [DATA_W-1:0] localFineApplied,
  input wire logic [DATA_W-1:0] digitalFineApplied,
  input wire logic [DATA_W-1:0] digitalSuperApplied,
  // sync events, flags and clock status
  input wire logic syncSetupErr,
  input wire logic syncHoldErr,
  input wire logic syncSetupFlag,
  input wire logic syncHoldFlag,
  input wire logic syncFlagsHeld,
  input wire logic clockPresent
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // error event followed by a cycle with flags released
  sequence s_setup_ev;
    syncSetupErr ##1 !syncFlagsHeld;
  endsequence
  sequence s_hold_ev;
    syncHoldErr ##1 !syncFlagsHeld;
  endsequence
  property p_rd_idle;
    !$past(regRd) |-> regRdata == 8'h00;
  endproperty
  property p_local_max;
    localFineApplied <= FINE_MAX;
  endproperty
  property p_dig_max;
    digitalFineApplied <= FINE_MAX;
  endproperty
  property p_super_max;
    digitalSuperApplied <= SUPER_MAX;
  endproperty
  property p_status_rd;
    regRd && regAddr == OFS_CLK_STATUS |=>
      regRdata == {7'h00, $past(clockPresent)};
  endproperty
  // each flag follows its own event, so a swap is caught
  property p_flag_set;
    s_setup_ev |-> syncSetupFlag;
  endproperty
  property p_hold_set;
    s_hold_ev |-> syncHoldFlag;
  endproperty
  property p_flag_keep;
    syncSetupFlag ##1 !syncFlagsHeld |-> syncSetupFlag;
  endproperty
  property p_flag_clear;
    syncFlagsHeld |-> !syncSetupFlag && !syncHoldFlag;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  a_local_max: assert property (p_local_max)
    else $error("local fine above limit");
  a_dig_max: assert property (p_dig_max)
    else $error("digital fine above limit");
  a_super_max: assert property (p_super_max)
    else $error("super fine above limit");
  a_status_rd: assert property (p_status_rd)
    else $error("status read mismatch");
  a_flag_set: assert property (p_flag_set)
    else $error("sync flag not set");
  a_hold_set: assert property (p_hold_set)
    else $error("hold flag not set");
  a_flag_keep: assert property (p_flag_keep)
    else $error("sync flag lost");
  a_flag_clear: assert property (p_flag_clear)
    else $error("sync flag set while held");
endmodule : scd_regs_checker
bind scd_regs scd_regs_checker u_chk (.mclk, .rst, .regAddr, .regRd,
  .regRdata, .localFineApplied, .digitalFineApplied, .digitalSuperApplied,
  .syncSetupErr, .syncHoldErr, .syncSetupFlag, .syncHoldFlag,
  .syncFlagsHeld, .clockPresent);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// register-level bench for the clock delay and detect block
module testbench
  import scd_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic clkMonitor = 1'b0;
  logic syncSetupErr = 1'b0;
  logic syncHoldErr = 1'b0;
  logic [DATA_W-1:0] regRdata, lfa, dfa, dsa;
  logic fineLimited, s1a, s1p, s2a, s2p, sFlag, hFlag, held, pres, irq;
  int num_errors = 0;
  int num_checks = 0;
  int monHalf = 0; // monitored half period in mclk, 0 keeps it still
  int monCnt = 0;
  logic [7:0] m;
  logic [2:0] modes [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
  logic [11:0] ra [10] = '{12'h112, 12'h113, 12'h114, 12'h11A, 12'h11B,
    12'h11C, 12'h11E, 12'h120, 12'h110, 12'h1FF};
  logic [7:0] rv [10] = '{8'hC0, 8'h00, 8'hC0, 8'h0E, 8'h00, 8'h03,
    8'h03, 8'h00, 8'h00, 8'h00};
  scd_regs i_dut (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .clkMonitor, .syncSetupErr, .syncHoldErr,
    .localFineApplied(lfa), .digitalFineApplied(dfa),
    .digitalSuperApplied(dsa), .fineLimited, .stabilizerOneActive(s1a),
    .stabilizerOnePowered(s1p), .stabilizerTwoActive(s2a),
    .stabilizerTwoPowered(s2p), .syncSetupFlag(sFlag), .syncHoldFlag(hFlag),
    .syncFlagsHeld(held), .clockPresent(pres), .irq);
  // 250 MHz system clock
  initial begin
    forever #2 mclk = ~mclk;
  end
  // monitored clock made from mclk, phase unrelated to reads
  always @(posedge mclk) begin
    if (monHalf == 0) begin
      monCnt <= 0;
    end else if (monCnt >= monHalf - 1) begin
      monCnt <= 0;
      clkMonitor <= ~clkMonitor;
    end else begin
      monCnt <= monCnt + 1;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  // read data sampled in the cycle after the strobe only
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask : rd
  // chosen capture errors for one cycle
  task automatic sync_pulse(input logic s, input logic h);
    @(posedge mclk);
    syncSetupErr <= s;
    syncHoldErr <= h;
    @(posedge mclk);
    syncSetupErr <= 1'b0;
    syncHoldErr <= 1'b0;
    cyc(3);
  endtask : sync_pulse
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // hang guard
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    chk({4'h0, s1a, s1p, s2a, s2p}, 8'h0F);
    $display("done: reset");
    wr(OFS_LOCAL_FINE, 8'h55);
    wr(OFS_DIG_SUPER, 8'h22);
    wr(OFS_DIG_FINE, 8'h33);
    foreach (modes[i]) begin
      wr(OFS_DELAY_MODE, {5'h00, modes[i]});
      cyc(2);
      m = (modes[i] inside {3'h2, 3'h3, 3'h4, 3'h6}) ? 8'hFF : 8'h00;
      chk(lfa, m & 8'h55);
      chk(dfa, m & 8'h33);
      chk(dsa, (modes[i] inside {3'h2, 3'h6}) ? 8'h22 : 8'h00);
      chk({7'h0, fineLimited}, {7'h0, modes[i][2:1] == 2'h1});
    end
    wr(OFS_LOCAL_FINE, 8'hC8);
    wr(OFS_DIG_SUPER, 8'h90);
    cyc(2);
    chk(lfa, 8'hC0);
    chk(dsa, 8'h80);
    rd(OFS_LOCAL_FINE, 8'hC8);
    wr(OFS_STAB_ONE, 8'h02);
    wr(OFS_STAB_TWO, 8'h01);
    cyc(2);
    chk({4'h0, s1a, s1p, s2a, s2p}, 8'h09);
    $display("done: delays");
    sync_pulse(1'b1, 1'b0);
    chk({6'h0, sFlag, hFlag}, 8'h02);
    wr(OFS_SYNC_CTRL, 8'hFF);
    sync_pulse(1'b1, 1'b1);
    chk({5'h0, held, sFlag, hFlag}, 8'h04);
    rd(OFS_SYNC_CTRL, 8'h5E);
    wr(OFS_SYNC_CTRL, 8'h00);
    cyc(3);
    chk({5'h0, held, sFlag, hFlag}, 8'h00);
    sync_pulse(1'b0, 1'b1);
    chk({6'h0, sFlag, hFlag}, 8'h01);
    sync_pulse(1'b1, 1'b0);
    chk({6'h0, sFlag, hFlag}, 8'h03);
    rd(OFS_IRQ_STATUS, 8'h04);
    wr(OFS_IRQ_STATUS, 8'h07);
    $display("done: sync flags");
    monHalf = 2;
    cyc(800);
    chk({7'h0, pres}, 8'h01);
    rd(OFS_CLK_STATUS, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_IRQ_MASK, 8'h00);
    cyc(3);
    chk({7'h0, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h07);
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    wr(OFS_IRQ_STATUS, 8'h01);
    cyc(3);
    rd(OFS_IRQ_STATUS, 8'h00);
    chk({7'h0, irq}, 8'h00);
    monHalf = 0;
    cyc(800);
    wr(OFS_CLK_STATUS, 8'hFF);
    rd(OFS_CLK_STATUS, 8'h00);
    rd(OFS_IRQ_STATUS, 8'h02);
    wr(OFS_IRQ_STATUS, 8'h02);
    monHalf = 20;
    cyc(800);
    chk({7'h0, pres}, 8'h00);
    wr(OFS_DETECT_CTRL, 8'h1E);
    cyc(800);
    chk({7'h0, pres}, 8'h01);
    rd(OFS_DETECT_CTRL, 8'h1E);
    $display("done: detect");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
